/* pkg/hpfd_defs.vh */
// Operation
// - on halt request, any frame already being sent finishes first.
// - final frame status clears halt and transmitter-on and pulses tx stopped in the same cycle.
// - host sets transmitter-on to restart.
// - receive words from the mac layer enter the data fifo, pointer advancing.
// - one status word per packet goes into its own status fifo.
// - a readable level register shows data amount and status word count.
// - status and data fifos are popped independently, status first allowed.
// - reading an empty receive fifo sets the receiver error flag.
// - each packet start is shifted by a programmed 0 to 31 byte offset.
// - optional filler words round each packet to a whole host burst.
// - offset and padding are applied to each packet separately.
// - skip bit discards the head packet, read pointer to next packet.
// - skip touches only the data fifo; status still has to be popped.
// - skip works with the receiver still enabled.
// - dump bit resets both receive fifo pointers and then clears itself.
// - host moves each 32-bit fifo word as two 16-bit halves.
// - clearing receiver enable leads to a receiver stopped pulse once halted.
// - status fifo underrun or overrun also sets the error flag.
`ifndef HPFD_DEFS_VH
`define HPFD_DEFS_VH
`define HPFD_OFF_RX_DATA 8'h00
`define HPFD_OFF_RX_STAT 8'h04
`define HPFD_OFF_LEVEL 8'h08
`define HPFD_OFF_RX_CFG 8'h0C
`define HPFD_OFF_TX_CFG 8'h10
`define HPFD_OFF_INT_STS 8'h14
`define HPFD_OFF_DP_CTRL 8'h18
`define HPFD_OFF_MAC_CR 8'h1C
`define HPFD_RXCFG_PAD_BIT 8
`define HPFD_RXCFG_BSEL_LO 9
`define HPFD_RXCFG_DUMP_BIT 15
`define HPFD_TXCFG_ON_BIT 0
`define HPFD_TXCFG_HALT_BIT 1
`define HPFD_INT_RXERR_BIT 0
`define HPFD_DPCTRL_SKIP_BIT 31
`define HPFD_MACCR_RECEIVER_ENABLE_BIT_BIT 2
`define HPFD_RXCFG_RESET 11'h000
`define HPFD_DDEPTH 64
`define HPFD_SDEPTH 16
`define HPFD_READY_LIMIT 7'h3D
`define HPFD_WR_IDLE 3'h0
`define HPFD_WR_LEAD 3'h1
`define HPFD_WR_STRM 3'h2
`define HPFD_WR_FLSH 3'h3
`define HPFD_WR_PAD 3'h4
`define HPFD_WR_STAT 3'h5
`endif

/* verilog/hpfd_top.v */
`timescale 1ns/1ps
`include "hpfd_defs.vh"
module hpfd_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire mac_data_valid,
    input wire [31:0] mac_data,
    input wire mac_status_valid,
    input wire [31:0] mac_status,
    output reg mac_ready,
    input wire tx_frame_busy,
    input wire tx_status_valid,
    output reg tx_enable,
    output reg tx_halt_req,
    output reg tx_stopped_pulse,
    input wire rx_halted,
    output reg rx_enable,
    output reg rx_stopped_pulse
);
    reg [32:0] dmem [0:`HPFD_DDEPTH-1];
    reg [31:0] smem [0:`HPFD_SDEPTH-1];
    reg [6:0] d_wr;
    reg [6:0] d_rd;
    reg [4:0] s_wr;
    reg [4:0] s_rd;
    reg d_half;
    reg s_half;
    reg [10:0] rx_cfg;
    reg rx_dump;
    reg rx_skip;
    reg skip_popped;
    reg rx_error_flag;
    reg rx_stop_pend;
    reg [2:0] wr_state;
    reg [2:0] next_state;
    reg [31:0] carry;
    reg [1:0] shift;
    reg [2:0] lead_cnt;
    reg [3:0] wcnt;
    reg [3:0] bmask;
    reg pad_en;
    reg first_pend;
    reg [31:0] stat_hold;
    reg [31:0] rd_mux;
    reg map_ok;
    reg wr_en;
    reg [31:0] wr_word;
    wire [6:0] d_level = d_wr - d_rd;
    wire [4:0] s_level = s_wr - s_rd;
    wire d_empty = (d_level == 7'h00);
    wire d_full = (d_level == 7'h40);
    wire s_empty = (s_level == 5'h00);
    wire s_full = (s_level == 5'h10);
    wire [32:0] d_head = dmem[d_rd[5:0]];
    wire [31:0] s_head = smem[s_rd[3:0]];
    wire apb_done = psel & penable & pready;
    wire apb_wr = apb_done & pwrite;
    wire apb_rd = apb_done & ~pwrite;
    wire hit_data = (paddr == `HPFD_OFF_RX_DATA);
    wire hit_stat = (paddr == `HPFD_OFF_RX_STAT);
    wire d_host_rd = apb_rd & hit_data & ~rx_skip;
    wire s_host_rd = apb_rd & hit_stat;
    wire d_pop_host = d_host_rd & d_half & ~d_empty;
    wire s_pop_host = s_host_rd & s_half & ~s_empty;
    wire d_under = d_host_rd & ~d_half & d_empty;
    wire s_under = s_host_rd & ~s_half & s_empty;
    wire skip_pop = rx_skip & ~d_empty & (~skip_popped | ~d_head[32]);
    wire skip_done = rx_skip & skip_popped & ((~d_empty & d_head[32]) | (d_empty & wr_state == `HPFD_WR_IDLE));
    wire mac_take = mac_data_valid & mac_ready;
    wire stat_take = mac_status_valid & mac_ready & ~mac_data_valid;
    wire [5:0] sh_amt = 6'h20 - {1'b0, shift, 3'b000};
    wire [63:0] strm_cat = {mac_data, carry} >> sh_amt;
    wire [63:0] flsh_cat = {32'h0000_0000, carry} >> sh_amt;
    wire pad_need = pad_en & ((wcnt & bmask) != 4'h0);
    wire stat_wr = (wr_state == `HPFD_WR_STAT) & ~s_full;
    wire stat_over = (wr_state == `HPFD_WR_STAT) & s_full;
    wire halt_done = tx_halt_req & (tx_status_valid | ~tx_frame_busy);

    always @* begin
        map_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `HPFD_OFF_RX_DATA: rd_mux = (d_empty | rx_skip) ? 32'h0000_0000 :
                (d_half ? {16'h0000, d_head[31:16]} : {16'h0000, d_head[15:0]});
            `HPFD_OFF_RX_STAT: rd_mux = s_empty ? 32'h0000_0000 :
                (s_half ? {16'h0000, s_head[31:16]} : {16'h0000, s_head[15:0]});
            `HPFD_OFF_LEVEL: rd_mux = {11'h000, s_level, 7'h00, d_level, 2'b00};
            `HPFD_OFF_RX_CFG: rd_mux = {16'h0000, rx_dump, 4'h0, rx_cfg};
            `HPFD_OFF_TX_CFG: rd_mux = {30'h0000_0000, tx_halt_req, tx_enable};
            `HPFD_OFF_INT_STS: rd_mux = {31'h0000_0000, rx_error_flag};
            `HPFD_OFF_DP_CTRL: rd_mux = {rx_skip, 31'h0000_0000};
            `HPFD_OFF_MAC_CR: rd_mux = {29'h0000_0000, rx_enable, 2'b00};
            default: map_ok = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            // one wait state, data loaded with pready
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~map_ok;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    always @* begin
        next_state = wr_state;
        wr_en = 1'b0;
        wr_word = 32'h0000_0000;
        case (wr_state)
            `HPFD_WR_IDLE: begin
                if (mac_data_valid | mac_status_valid) begin
                    next_state = `HPFD_WR_LEAD;
                end
            end
            `HPFD_WR_LEAD: begin
                if (lead_cnt == 3'h0) begin
                    next_state = `HPFD_WR_STRM;
                end else if (!d_full) begin
                    wr_en = 1'b1;
                end
            end
            `HPFD_WR_STRM: begin
                if (mac_take) begin
                    wr_en = 1'b1;
                    wr_word = strm_cat[31:0];
                end else if (stat_take) begin
                    next_state = `HPFD_WR_FLSH;
                end
            end
            `HPFD_WR_FLSH: begin
                if (shift == 2'b00) begin
                    next_state = `HPFD_WR_PAD;
                end else if (!d_full) begin
                    wr_en = 1'b1;
                    wr_word = flsh_cat[31:0];
                    next_state = `HPFD_WR_PAD;
                end
            end
            `HPFD_WR_PAD: begin
                if (!pad_need) begin
                    next_state = `HPFD_WR_STAT;
                end else if (!d_full) begin
                    wr_en = 1'b1;
                end
            end
            `HPFD_WR_STAT: next_state = `HPFD_WR_IDLE;
            default: next_state = `HPFD_WR_IDLE;
        endcase
    end

    always @(posedge pclk) begin
        if (wr_en) begin
            dmem[d_wr[5:0]] <= {first_pend, wr_word};
        end
        if (stat_wr) begin
            smem[s_wr[3:0]] <= stat_hold;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_state <= `HPFD_WR_IDLE;
            mac_ready <= 1'b0;
            carry <= 32'h0000_0000;
            shift <= 2'b00;
            lead_cnt <= 3'h0;
            wcnt <= 4'h0;
            bmask <= 4'h0;
            pad_en <= 1'b0;
            first_pend <= 1'b0;
            stat_hold <= 32'h0000_0000;
            d_wr <= 7'h00;
            s_wr <= 5'h00;
        end else if (rx_dump) begin
            wr_state <= `HPFD_WR_IDLE;
            mac_ready <= 1'b0;
            first_pend <= 1'b0;
            d_wr <= 7'h00;
            s_wr <= 5'h00;
        end else begin
            wr_state <= next_state;
            mac_ready <= (next_state == `HPFD_WR_STRM) & (d_level < `HPFD_READY_LIMIT);
            if (wr_state == `HPFD_WR_IDLE && next_state == `HPFD_WR_LEAD) begin
                shift <= rx_cfg[1:0];
                lead_cnt <= rx_cfg[4:2];
                carry <= 32'h0000_0000;
                wcnt <= 4'h0;
                first_pend <= 1'b1;
                pad_en <= rx_cfg[`HPFD_RXCFG_PAD_BIT];
                bmask <= (4'h2 << rx_cfg[`HPFD_RXCFG_BSEL_LO+1:`HPFD_RXCFG_BSEL_LO]) - 4'h1;
            end
            if (wr_state == `HPFD_WR_LEAD && wr_en) begin
                lead_cnt <= lead_cnt - 3'h1;
            end
            if (mac_take) begin
                carry <= mac_data;
            end
            if (stat_take) begin
                stat_hold <= mac_status;
            end
            if (wr_en) begin
                d_wr <= d_wr + 7'h01;
                wcnt <= wcnt + 4'h1;
                first_pend <= 1'b0;
            end
            if (stat_wr) begin
                s_wr <= s_wr + 5'h01;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_rd <= 7'h00;
            s_rd <= 5'h00;
            d_half <= 1'b0;
            s_half <= 1'b0;
            rx_skip <= 1'b0;
            skip_popped <= 1'b0;
        end else if (rx_dump) begin
            d_rd <= 7'h00;
            s_rd <= 5'h00;
            d_half <= 1'b0;
            s_half <= 1'b0;
            rx_skip <= 1'b0;
            skip_popped <= 1'b0;
        end else begin
            if (d_host_rd && !d_empty) begin
                d_half <= ~d_half;
            end
            if (s_host_rd && !s_empty) begin
                s_half <= ~s_half;
            end
            if (d_pop_host || skip_pop) begin
                d_rd <= d_rd + 7'h01;
            end
            if (s_pop_host) begin
                s_rd <= s_rd + 5'h01;
            end
            if (skip_pop) begin
                skip_popped <= 1'b1;
            end
            if (skip_done) begin
                rx_skip <= 1'b0;
                skip_popped <= 1'b0;
            end else if (apb_wr && paddr == `HPFD_OFF_DP_CTRL && pwdata[`HPFD_DPCTRL_SKIP_BIT]) begin
                rx_skip <= 1'b1;
                d_half <= 1'b0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cfg <= `HPFD_RXCFG_RESET;
            rx_dump <= 1'b0;
            rx_error_flag <= 1'b0;
            tx_enable <= 1'b0;
            tx_halt_req <= 1'b0;
            tx_stopped_pulse <= 1'b0;
            rx_enable <= 1'b0;
            rx_stop_pend <= 1'b0;
            rx_stopped_pulse <= 1'b0;
        end else begin
            if (apb_wr && paddr == `HPFD_OFF_RX_CFG) begin
                rx_cfg <= pwdata[10:0];
            end
            if (rx_dump) begin
                rx_dump <= 1'b0;
            end else if (apb_wr && paddr == `HPFD_OFF_RX_CFG) begin
                rx_dump <= pwdata[`HPFD_RXCFG_DUMP_BIT];
            end
            rx_error_flag <= (rx_error_flag & ~(apb_wr && paddr == `HPFD_OFF_INT_STS &&
                pwdata[`HPFD_INT_RXERR_BIT])) | d_under | s_under | stat_over;
            tx_stopped_pulse <= halt_done & tx_enable;
            if (halt_done) begin
                tx_halt_req <= 1'b0;
                tx_enable <= 1'b0;
            end
            if (apb_wr && paddr == `HPFD_OFF_TX_CFG) begin
                if (pwdata[`HPFD_TXCFG_ON_BIT]) begin
                    tx_enable <= 1'b1;
                end
                if (pwdata[`HPFD_TXCFG_HALT_BIT]) begin
                    tx_halt_req <= 1'b1;
                end
            end
            rx_stopped_pulse <= rx_stop_pend & rx_halted;
            if (rx_stop_pend && rx_halted) begin
                rx_stop_pend <= 1'b0;
            end
            if (apb_wr && paddr == `HPFD_OFF_MAC_CR) begin
                rx_enable <= pwdata[`HPFD_MACCR_RECEIVER_ENABLE_BIT_BIT];
                if (rx_enable && !pwdata[`HPFD_MACCR_RECEIVER_ENABLE_BIT_BIT]) begin
                    rx_stop_pend <= 1'b1;
                end
            end
        end
    end
endmodule // hpfd_top

/* sim/hpfd_chk.sv */
`timescale 1ns/1ps
module hpfd_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic mac_data_valid,
    input logic mac_status_valid,
    input logic mac_ready,
    input logic tx_frame_busy,
    input logic tx_status_valid,
    input logic tx_enable,
    input logic tx_halt_req,
    input logic tx_stopped_pulse,
    input logic rx_halted,
    input logic rx_enable,
    input logic rx_stopped_pulse
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    bus_answer_a: assert property (
        psel && penable && !pready |-> ##[0:2] pready) else $error("no bus answer");
    bus_pulse_a: assert property (
        pready |=> !pready) else $error("pready too long");
    bus_err_a: assert property (
        pslverr |-> pready) else $error("pslverr without pready");
    halt_wait_a: assert property (
        tx_halt_req && tx_enable && tx_frame_busy && !tx_status_valid |=> tx_enable)
        else $error("tx stopped mid frame");
    tx_stop_a: assert property (
        tx_halt_req && tx_enable && tx_status_valid |=> tx_stopped_pulse && !tx_enable && !tx_halt_req)
        else $error("tx stop missing");
    stop_pulse_a: assert property (
        tx_stopped_pulse |=> !tx_stopped_pulse) else $error("tx stop pulse too long");
    rx_stop_a: assert property (
        rx_stopped_pulse |-> !rx_enable && $past(rx_halted) && !$past(rx_stopped_pulse))
        else $error("bad rx stop pulse");
    status_take_a: assert property (
        mac_status_valid && mac_ready && !mac_data_valid |=> !mac_ready) else $error("ready after status");
endmodule // hpfd_chk
bind hpfd_top hpfd_chk u_hpfd_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .mac_data_valid,
    .mac_status_valid, .mac_ready, .tx_frame_busy, .tx_status_valid, .tx_enable, .tx_halt_req,
    .tx_stopped_pulse, .rx_halted, .rx_enable, .rx_stopped_pulse);

/* sim/hpfd_mac_model.sv */
`timescale 1ns/1ps
module hpfd_mac_model (
    input logic pclk,
    input logic presetn,
    input logic mac_ready,
    input logic tx_enable,
    input logic tx_halt_req,
    input logic rx_enable,
    output logic mac_data_valid,
    output logic [31:0] mac_data,
    output logic mac_status_valid,
    output logic [31:0] mac_status,
    output logic tx_frame_busy,
    output logic tx_status_valid,
    output logic rx_halted
);
    logic [31:0] word = 32'h0;
    logic [31:0] stat = 32'h0;
    logic [31:0] junk = 32'h0;
    initial begin
        mac_data_valid = 1'b0;
        mac_status_valid = 1'b0;
        tx_frame_busy = 1'b0;
        tx_status_valid = 1'b0;
    end
    // idle lines toggle so a stale word never passes
    always @(posedge pclk) junk <= ~junk;
    assign mac_data = mac_data_valid ? word : junk;
    assign mac_status = mac_status_valid ? stat : junk;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) rx_halted <= 1'b1;
        else rx_halted <= !rx_enable;
    end
    task take;
        do @(posedge pclk); while (mac_ready !== 1'b1);
    endtask
    task automatic send_pkt(input int n, input logic [31:0] base);
        for (int i = 0; i < n; i++) begin
            word <= base + i;
            mac_data_valid <= 1'b1;
            take();
        end
        mac_data_valid <= 1'b0;
        stat <= {2'b00, 14'(n * 4), 16'h0000};
        mac_status_valid <= 1'b1;
        take();
        mac_status_valid <= 1'b0;
    endtask
    task automatic send_frame(input int len);
        if (tx_enable === 1'b1 && tx_halt_req !== 1'b1) begin
            tx_frame_busy <= 1'b1;
            repeat (len) @(posedge pclk);
            tx_frame_busy <= 1'b0;
            tx_status_valid <= 1'b1;
            @(posedge pclk);
            tx_status_valid <= 1'b0;
        end
    endtask
endmodule // hpfd_mac_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "hpfd_defs.vh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, mac_data, mac_status;
    logic mac_data_valid, mac_status_valid, mac_ready, tx_frame_busy, tx_status_valid;
    logic tx_enable, tx_halt_req, tx_stopped_pulse, rx_halted, rx_enable, rx_stopped_pulse;
    int fail_count = 0;
    int comparisons = 0;
    int tx_stops = 0;
    int rx_stops = 0;
    logic [31:0] exp [8] = '{0, 32'hA0000000, 32'hA0000001, 0, 0, 32'hB0000000, 32'hB0000001, 0};
    hpfd_top u_hpfd_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mac_data_valid, .mac_data, .mac_status_valid, .mac_status, .mac_ready, .tx_frame_busy,
        .tx_status_valid, .tx_enable, .tx_halt_req, .tx_stopped_pulse, .rx_halted, .rx_enable, .rx_stopped_pulse);
    hpfd_mac_model u_hpfd_mac_model (.pclk, .presetn, .mac_ready, .tx_enable, .tx_halt_req, .rx_enable,
        .mac_data_valid, .mac_data, .mac_status_valid, .mac_status, .tx_frame_busy, .tx_status_valid, .rx_halted);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (tx_stopped_pulse === 1'b1) tx_stops++;
        if (rx_stopped_pulse === 1'b1) rx_stops++;
    end
    task chk(input logic [31:0] got, input logic [31:0] want, input string what);
        comparisons++;
        if (got !== want) begin
            fail_count++;
            $display("FAIL %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd_word(input logic [7:0] a);
        logic [15:0] lo;
        apb(1'b0, a, 32'h0);
        lo = r[15:0];
        apb(1'b0, a, 32'h0);
        r = {r[15:0], lo};
    endtask
    task poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (r[b] === 1'b1 && n < 50);
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        // run needs about three hundred cycles
        repeat (20000) @(posedge pclk);
        fail_count++;
        test_done;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `HPFD_OFF_TX_CFG, 32'h1);
        fork
            u_hpfd_mac_model.send_frame(12);
            begin
                apb(1'b1, `HPFD_OFF_TX_CFG, 32'h2);
                chk(tx_enable, 1, "tx mid frame");
            end
        join
        repeat (3) @(posedge pclk);
        chk(tx_stops, 1, "tx stop pulses");
        chk({tx_enable, tx_halt_req}, 0, "tx off");
        apb(1'b1, `HPFD_OFF_TX_CFG, 32'h1);
        chk({tx_enable, tx_halt_req}, 2, "tx restart");
        $display("test tx done");
        apb(1'b1, `HPFD_OFF_MAC_CR, 32'h4);
        // offset one word, padding to two word bursts
        apb(1'b1, `HPFD_OFF_RX_CFG, 32'h104);
        u_hpfd_mac_model.send_pkt(2, 32'hA0000000);
        u_hpfd_mac_model.send_pkt(2, 32'hB0000000);
        repeat (8) @(posedge pclk);
        apb(1'b0, `HPFD_OFF_LEVEL, 32'h0);
        chk(r, 32'h00020020, "level");
        for (int i = 0; i < 2; i++) begin
            rd_word(`HPFD_OFF_RX_STAT);
            chk(r, 32'h00080000, "status");
        end
        for (int i = 0; i < 8; i++) begin
            rd_word(`HPFD_OFF_RX_DATA);
            chk(r, exp[i], "data");
        end
        $display("test rx format done");
        apb(1'b1, `HPFD_OFF_RX_CFG, 32'h0);
        u_hpfd_mac_model.send_pkt(5, 32'hC0000000);
        u_hpfd_mac_model.send_pkt(2, 32'hD0000000);
        repeat (8) @(posedge pclk);
        apb(1'b1, `HPFD_OFF_DP_CTRL, 32'h80000000);
        poll(`HPFD_OFF_DP_CTRL, 31);
        chk(r[31], 0, "skip bit");
        rd_word(`HPFD_OFF_RX_DATA);
        chk(r, 32'hD0000000, "after skip");
        apb(1'b0, `HPFD_OFF_LEVEL, 32'h0);
        chk(r, 32'h00020004, "level after skip");
        rd_word(`HPFD_OFF_RX_DATA);
        chk(r, 32'hD0000001, "rest of packet");
        apb(1'b1, `HPFD_OFF_RX_CFG, 32'h1);
        u_hpfd_mac_model.send_pkt(2, 32'h44332211);
        repeat (8) @(posedge pclk);
        rd_word(`HPFD_OFF_RX_DATA);
        chk(r, 32'h33221100, "byte offset head");
        rd_word(`HPFD_OFF_RX_DATA);
        chk(r, 32'h33221244, "byte offset middle");
        rd_word(`HPFD_OFF_RX_DATA);
        chk(r, 32'h00000044, "byte offset tail");
        $display("test byte offset done");
        apb(1'b1, `HPFD_OFF_MAC_CR, 32'h0);
        repeat (4) @(posedge pclk);
        chk(rx_stops, 1, "rx stop pulses");
        apb(1'b1, `HPFD_OFF_RX_CFG, 32'h8000);
        poll(`HPFD_OFF_RX_CFG, 15);
        chk(r[15], 0, "dump bit cleared");
        apb(1'b0, `HPFD_OFF_LEVEL, 32'h0);
        chk(r, 0, "level after dump");
        $display("test skip and dump done");
        apb(1'b0, `HPFD_OFF_RX_DATA, 32'h0);
        chk(r, 0, "empty read");
        apb(1'b0, `HPFD_OFF_INT_STS, 32'h0);
        chk(r[0], 1, "data underrun");
        apb(1'b1, `HPFD_OFF_INT_STS, 32'h1);
        apb(1'b0, `HPFD_OFF_INT_STS, 32'h0);
        chk(r[0], 0, "flag cleared");
        apb(1'b0, `HPFD_OFF_RX_STAT, 32'h0);
        apb(1'b0, `HPFD_OFF_INT_STS, 32'h0);
        chk(r[0], 1, "status underrun");
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, e}, 1, "unmapped error");
        chk(r, 0, "unmapped data");
        $display("test errors done");
        test_done;
    end
endmodule // tb_top
